// ===== supervisor_pkg.sv
// Package with constants and carrier types for the supervisor watchdog and reset core.
// Operation
// RULE1: Kick input idle 1.6 s declares timeout.
// RULE2: Floating kick input disables the watchdog.
// RULE3: Timer clears on reset, float, kick edge.
// RULE4: Expired output stays low until timer clears.
// RULE5: Expired output low during low supply.
// RULE6: No minimum low time for expired output.
// RULE7: Expired output rises at once when supply recovers.
// RULE8: Reset pulses 200 ms, held during low supply.
// RULE9: Reset pulse follows supply recovery and button release.
// RULE10: Timeout alone never starts a reset pulse.
// RULE11: Active-high reset is exact complement of reset.
// RULE12: Power-fail flag low when sense below level.
// RULE13: Manual reset input low triggers reset pulse.
// RULE14: Brownout mid-pulse extends pulse at least 140 ms.
// RULE15: Timer counts only after reset release and driven input.
// RULE16: Analog condition flags synchronised before use.
// RULE17: Durations counted in clock cycles from frequency.
package supervisor_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned WDOG_TIMEOUT_MS = 1600;
	localparam int unsigned RESET_PULSE_MS = 200;
	localparam int unsigned BROWNOUT_EXT_MS = 140;
	// Cycle counts derived from the clock rate; minimum times round up.
	localparam longint WDOG_CYCLES = (longint'(WDOG_TIMEOUT_MS) * CLK_HZ) / 1000;
	localparam longint RESET_CYCLES = (longint'(RESET_PULSE_MS) * CLK_HZ + 999) / 1000;
	localparam longint BROWNOUT_CYCLES = (longint'(BROWNOUT_EXT_MS) * CLK_HZ + 999) / 1000;
	// Synchroniser reset value: low supply and released button, so the core starts held in reset.
	localparam logic [3:0] FLAGS_RESET = 4'h9;

	// Condition flags from the analog front end.
	typedef struct packed {
		logic supply_low;
		logic power_fail_low;
		logic kick_floating;
		logic manual_reset_n;
	} flags_s;
endpackage

// ===== flag_sync.sv
// Two-stage synchroniser for a bundle of condition flags.
`timescale 1ns/1ns
`default_nettype none
module flag_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_reg;

	// An empty bundle has nothing to carry.
	if (WIDTH < 1) begin : g_bad_width
		$error("flag_sync: width must be at least one");
	end

	// The first stage is read only by the second stage.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_reg <= RESET_VALUE;
			o_sync <= RESET_VALUE;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule // flag_sync
`default_nettype wire

// ===== supervisor_watchdog_reset.sv
// Supervisor core: watchdog timer, reset pulse generator and power-fail flag.
`timescale 1ns/1ns
`default_nettype none
module supervisor_watchdog_reset #(
	parameter longint WDOG_COUNT = supervisor_pkg::WDOG_CYCLES,
	parameter longint RESET_COUNT = supervisor_pkg::RESET_CYCLES,
	parameter longint BROWNOUT_COUNT = supervisor_pkg::BROWNOUT_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire supervisor_pkg::flags_s i_flags,
	input wire logic i_watchdog_kick,
	output logic o_reset_n,
	output logic o_reset,
	output logic o_watchdog_expired_n,
	output logic o_power_fail_flag
);
	import supervisor_pkg::*;

	localparam int CW = 32;

	// Refuse counts that do not fit the counter or are too short.
	if (WDOG_COUNT < 2 || WDOG_COUNT >= (longint'(1) << CW) || RESET_COUNT < 2 ||
		RESET_COUNT >= (longint'(1) << CW) || BROWNOUT_COUNT < 1 || BROWNOUT_COUNT > RESET_COUNT) begin : g_bad_counts
		$error("supervisor_watchdog_reset: unsupported count parameters");
	end

	typedef enum logic [1:0] {ST_HOLD, ST_PULSE, ST_RUN} rst_state_e;

	flags_s flags_sync;
	logic kick_s1_reg, kick_sync_reg, kick_last_reg;
	logic kick_edge;
	logic [CW-1:0] wdog_cnt_reg;
	logic wdog_expired_reg;
	logic [CW-1:0] rst_cnt_reg;
	rst_state_e rst_state_reg;
	logic wdog_clear;
	logic [CW-1:0] low_cnt_reg;

	// Condition flags cross in through a shared synchroniser.
	flag_sync #(.WIDTH(4), .RESET_VALUE(FLAGS_RESET)) u_flag_sync ( // see RULE16
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_async(i_flags),
		.o_sync(flags_sync)
	);

	// Kick input synchroniser and edge memory; the edge compares stage two with its history.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			kick_s1_reg <= 1'b0;
			kick_sync_reg <= 1'b0;
			kick_last_reg <= 1'b0;
		end else begin
			kick_s1_reg <= i_watchdog_kick;
			kick_sync_reg <= kick_s1_reg;
			kick_last_reg <= kick_sync_reg;
		end
	end

	assign kick_edge = kick_sync_reg ^ kick_last_reg; // see RULE3

	// Timer stays cleared under reset, while floating and on every kick edge.
	assign wdog_clear = (rst_state_reg != ST_RUN) || flags_sync.kick_floating || kick_edge; // see RULE3, see RULE15

	// Watchdog counter, frozen once timed out.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wdog_cnt_reg <= '0;
		end else if (wdog_clear) begin // see RULE2
			wdog_cnt_reg <= '0;
		end else if (wdog_cnt_reg != CW'(WDOG_COUNT - 1)) begin
			wdog_cnt_reg <= wdog_cnt_reg + 1'b1; // see RULE17
		end
	end

	// Expiry latch: set at full count, released only when the timer clears.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wdog_expired_reg <= 1'b0;
		end else if (wdog_clear) begin
			wdog_expired_reg <= 1'b0;
		end else if (wdog_cnt_reg == CW'(WDOG_COUNT - 2)) begin
			wdog_expired_reg <= 1'b1; // see RULE1, see RULE4
		end
	end

	// Expired output: low on timeout or low supply, high again with no hold time.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_watchdog_expired_n <= 1'b0;
		end else begin
			o_watchdog_expired_n <= !(flags_sync.supply_low || wdog_expired_reg); // see RULE5, see RULE6, see RULE7
		end
	end

	// Reset sequencer: held during low supply or button, then a timed pulse.
	// The watchdog expiry is deliberately not an input here.
	always_ff @(posedge i_clk or negedge i_reset_n) begin // see RULE10
		if (!i_reset_n) begin
			rst_state_reg <= ST_HOLD;
			rst_cnt_reg <= '0;
		end else if (flags_sync.supply_low || !flags_sync.manual_reset_n) begin // see RULE8, see RULE13
			rst_state_reg <= ST_HOLD;
			// A brownout mid-pulse keeps at least the extension ahead.
			if (rst_state_reg == ST_PULSE && rst_cnt_reg < CW'(BROWNOUT_COUNT))
				rst_cnt_reg <= CW'(BROWNOUT_COUNT); // see RULE14
			else if (rst_state_reg != ST_PULSE)
				rst_cnt_reg <= CW'(RESET_COUNT);
		end else begin
			case (rst_state_reg)
				ST_HOLD: begin
					rst_state_reg <= ST_PULSE; // see RULE9
					if (rst_cnt_reg < CW'(BROWNOUT_COUNT))
						rst_cnt_reg <= CW'(RESET_COUNT);
				end
				ST_PULSE: begin
					if (rst_cnt_reg <= 1)
						rst_state_reg <= ST_RUN;
					else
						rst_cnt_reg <= rst_cnt_reg - 1'b1;
				end
				ST_RUN: rst_cnt_reg <= '0;
				default: rst_state_reg <= ST_HOLD;
			endcase
		end
	end

	// Reset outputs are complementary registers.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_reset_n <= 1'b0;
			o_reset <= 1'b1;
		end else begin
			o_reset_n <= (rst_state_reg == ST_RUN); // see RULE8
			o_reset <= (rst_state_reg != ST_RUN); // see RULE11
		end
	end

	// Length of the current reset-low interval, saturating; only the pulse-width assertion reads it.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			low_cnt_reg <= '0;
		end else if (o_reset_n) begin
			low_cnt_reg <= '0;
		end else if (low_cnt_reg != '1) begin
			low_cnt_reg <= low_cnt_reg + 1'b1;
		end
	end

	// Power-fail flag follows the comparator.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_power_fail_flag <= 1'b0;
		end else begin
			o_power_fail_flag <= !flags_sync.power_fail_low; // see RULE12
		end
	end

	property p_complement;
		@(posedge i_clk) disable iff (!i_reset_n) o_reset == !o_reset_n;
	endproperty
	a_complement: assert property (p_complement) else $error("reset outputs not complementary"); // see RULE11

	property p_supply_low_wdo;
		@(posedge i_clk) disable iff (!i_reset_n) flags_sync.supply_low |=> !o_watchdog_expired_n;
	endproperty
	a_supply_low_wdo: assert property (p_supply_low_wdo) else $error("expired output high in low supply"); // see RULE5

	property p_recover_wdo;
		@(posedge i_clk) disable iff (!i_reset_n)
			(!flags_sync.supply_low && !wdog_expired_reg) |=> o_watchdog_expired_n;
	endproperty
	a_recover_wdo: assert property (p_recover_wdo) else $error("expired output delayed"); // see RULE6, see RULE7

	property p_supply_hold;
		@(posedge i_clk) disable iff (!i_reset_n) flags_sync.supply_low |=> ##1 !o_reset_n;
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("reset released in low supply"); // see RULE8

	property p_manual;
		@(posedge i_clk) disable iff (!i_reset_n) !flags_sync.manual_reset_n |=> ##1 !o_reset_n;
	endproperty
	a_manual: assert property (p_manual) else $error("manual reset ignored"); // see RULE13

	property p_release_pulse;
		@(posedge i_clk) disable iff (!i_reset_n)
			(rst_state_reg == ST_HOLD) ##1 (rst_state_reg == ST_PULSE) |-> !o_reset_n [*2];
	endproperty
	a_release_pulse: assert property (p_release_pulse) else $error("reset pulse missing"); // see RULE9

	property p_float_clear;
		@(posedge i_clk) disable iff (!i_reset_n) flags_sync.kick_floating |=> wdog_cnt_reg == '0 && !wdog_expired_reg;
	endproperty
	a_float_clear: assert property (p_float_clear) else $error("timer runs while floating"); // see RULE2

	property p_edge_clear;
		@(posedge i_clk) disable iff (!i_reset_n) kick_edge |=> wdog_cnt_reg == '0;
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("kick edge did not clear timer"); // see RULE3

	property p_no_count_in_reset;
		@(posedge i_clk) disable iff (!i_reset_n) (rst_state_reg != ST_RUN) |=> wdog_cnt_reg == '0; 
	endproperty
	a_no_count_in_reset: assert property (p_no_count_in_reset) else $error("timer counts in reset"); // see RULE15

	property p_timeout;
		@(posedge i_clk) disable iff (!i_reset_n)
			(!wdog_clear && wdog_cnt_reg == CW'(WDOG_COUNT - 2)) |=> ##1 !o_watchdog_expired_n;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout not signalled"); // see RULE1

	property p_expired_hold;
		@(posedge i_clk) disable iff (!i_reset_n) (wdog_expired_reg && !wdog_clear) |=> wdog_expired_reg;
	endproperty
	a_expired_hold: assert property (p_expired_hold) else $error("expiry released early"); // see RULE4

	property p_pfo;
		@(posedge i_clk) disable iff (!i_reset_n) flags_sync.power_fail_low |=> !o_power_fail_flag;
	endproperty
	a_pfo: assert property (p_pfo) else $error("power-fail flag wrong"); // see RULE12

	property p_min_pulse;
		@(posedge i_clk) disable iff (!i_reset_n) $rose(o_reset_n) |-> low_cnt_reg >= CW'(BROWNOUT_COUNT);
	endproperty
	a_min_pulse: assert property (p_min_pulse) else $error("reset pulse too short"); // see RULE14
endmodule // supervisor_watchdog_reset
`default_nettype wire

// ===== kick_partner.sv
// Microprocessor model that toggles the watchdog kick pin.
`timescale 1ns/1ns
`default_nettype none
module kick_partner (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_kick
);
	logic [1:0] div_reg = 2'h0;
	logic kick_reg = 1'b0;
	// While running the kick toggles every fourth cycle; a stalled program leaves it still.
	always @(posedge i_clk) begin
		if (i_run) begin
			div_reg <= div_reg + 2'h1;
			if (div_reg == 2'h3) begin
				kick_reg <= ~kick_reg;
			end
		end
	end
	assign o_kick = kick_reg;
endmodule // kick_partner
`default_nettype wire

// ===== testbench.sv
// Self-checking testbench for the supervisor watchdog and reset core.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import supervisor_pkg::*;
	localparam int WDOG = 40;
	localparam int RST = 20;
	localparam int BRN = 14;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	flags_s flags = '{1'b0, 1'b0, 1'b0, 1'b1};
	logic run = 1'b1;
	wire logic kick;
	logic reset_n, reset, wexp_n, pf;
	int n_fail = 0;
	int n_tests = 0;

	always #10 i_clk = ~i_clk;

	kick_partner cpu (.i_clk(i_clk), .i_run(run), .o_kick(kick));
	supervisor_watchdog_reset #(.WDOG_COUNT(WDOG), .RESET_COUNT(RST), .BROWNOUT_COUNT(BRN)) dut (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_flags(flags), .i_watchdog_kick(kick),
		.o_reset_n(reset_n), .o_reset(reset), .o_watchdog_expired_n(wexp_n), .o_power_fail_flag(pf));

	// Selects an output by number so one wait task serves reset_n, wexp_n and pf.
	function automatic logic pick(input int sel);
		return (sel == 0) ? reset_n : (sel == 1) ? wexp_n : pf;
	endfunction

	task automatic cycles(input int n);
		repeat (n) @(posedge i_clk);
		#2;
	endtask

	task automatic check(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Waits for an output level and judges the cycle count against a window.
	task automatic wait_for(input int sel, input logic v, input int lo, input int hi);
		int n;
		n = 0;
		while (pick(sel) !== v && n <= hi) begin
			cycles(1);
			n++;
		end
		n_tests++;
		if (n < lo || n > hi) begin
			n_fail++;
			$display("Error at %0t: waited %h cycles, window %h to %h", $time, n, lo, hi);
		end
		check(reset, ~reset_n);
	endtask

	task automatic t_power_on();
		check(reset_n, 1'b0);
		wait_for(0, 1'b1, RST - 2, RST + 10);
		$display("power-on test done");
	endtask

	task automatic t_timeout();
		run = 1'b0;
		wait_for(1, 1'b0, WDOG - 6, WDOG + 8);
		cycles(10);
		check(wexp_n, 1'b0);
		check(reset_n, 1'b1);
		run = 1'b1;
		wait_for(1, 1'b1, 1, 12);
		cycles(2 * WDOG);
		check(wexp_n, 1'b1);
		$display("timeout test done");
	endtask

	task automatic t_float();
		flags.kick_floating = 1'b1;
		run = 1'b0;
		cycles(3 * WDOG);
		check(wexp_n, 1'b1);
		flags.kick_floating = 1'b0;
		wait_for(1, 1'b0, WDOG - 2, WDOG + 8);
		run = 1'b1;
		wait_for(1, 1'b1, 1, 12);
		$display("float test done");
	endtask

	task automatic t_supply();
		flags.supply_low = 1'b1;
		wait_for(1, 1'b0, 1, 6);
		wait_for(0, 1'b0, 0, 6);
		flags.supply_low = 1'b0;
		wait_for(1, 1'b1, 1, 6);
		wait_for(0, 1'b1, RST - 4, RST + 8);
		$display("supply test done");
	endtask

	task automatic t_button_brownout();
		flags.manual_reset_n = 1'b0;
		wait_for(0, 1'b0, 1, 6);
		flags.manual_reset_n = 1'b1;
		cycles(RST - 6);
		check(reset_n, 1'b0);
		flags.supply_low = 1'b1;
		cycles(2);
		flags.supply_low = 1'b0;
		// A brownout seen on two edges restarts the full period once supply is back.
		wait_for(0, 1'b1, RST - 4, RST + 8);
		$display("button and brownout test done");
	endtask

	// A one-cycle brownout late in a pulse must leave at least the extension ahead.
	task automatic t_short_brownout();
		flags.manual_reset_n = 1'b0;
		cycles(2);
		flags.manual_reset_n = 1'b1;
		cycles(RST - 6);
		check(reset_n, 1'b0);
		flags.supply_low = 1'b1;
		cycles(1);
		flags.supply_low = 1'b0;
		wait_for(0, 1'b1, BRN, BRN + 8);
		$display("short brownout test done");
	endtask

	task automatic t_power_fail();
		flags.power_fail_low = 1'b1;
		wait_for(2, 1'b0, 1, 6);
		flags.power_fail_low = 1'b0;
		wait_for(2, 1'b1, 1, 6);
		$display("power-fail test done");
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Main sequence: reset for three cycles, then each scenario in turn.
	initial begin
		cycles(3);
		i_reset_n = 1'b1;
		cycles(1);
		t_power_on();
		t_timeout();
		t_float();
		t_supply();
		t_button_brownout();
		t_short_brownout();
		t_power_fail();
		report_and_stop();
	end

	// Cuts a hang short well beyond the expected run of about 450 cycles.
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule // testbench
`default_nettype wire
